//--- hdl/cmf_pkg.sv
// Constants, register layout and decoders shared by the message queue control.
package cmf_pkg;
    localparam int NumFifo = 7;
    // Byte address of a queue register is queue index * 16 + register offset.
    localparam logic [1:0] CfgHighSel = 2'h0;
    localparam logic [1:0] CtrlLowSel = 2'h1;
    localparam logic [1:0] StatusSel = 2'h2;
    localparam logic [7:0] ModeRegAddr = 8'h70;
    localparam logic [15:0] CfgHighRst = 16'h0060;
    localparam logic [7:0] CtrlLowRst = 8'h00;
    localparam logic [2:0] ModeRst = 3'h4;
    localparam logic [2:0] ConfigMode = 3'h4;
    // Queue configuration high fields.
    localparam int PayLo = 13;
    localparam int DepthLo = 8;
    localparam int RetryLo = 5;
    localparam int PrioLo = 0;
    localparam logic [7:0] CfgLowMask = 8'h7f;
    // Queue control low fields.
    localparam int FlushBit = 10;
    localparam int ReqBit = 9;
    localparam int AdvBit = 8;
    localparam int DirBit = 7;
    localparam int RtrBit = 6;
    localparam int TsBit = 5;
    // Queue status fields.
    localparam int ExhBit = 4;
    localparam int OvfBit = 3;
    // Mode register field and retry attempt limits.
    localparam int RetryEnBit = 3;
    localparam logic [1:0] NoRetryTries = 2'h1;
    localparam logic [1:0] ThreeTries = 2'h3;

    function automatic logic [6:0] decodePayload(input logic [2:0] s);
        case (s)
            3'h0: return 7'h08;
            3'h1: return 7'h0c;
            3'h2: return 7'h10;
            3'h3: return 7'h14;
            3'h4: return 7'h18;
            3'h5: return 7'h20;
            3'h6: return 7'h30;
            default: return 7'h40;
        endcase
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] nw,
                                            input logic [1:0] strb);
        return {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
    endfunction
endpackage

//--- hdl/cmf_fifo_ctrl.sv
// Control and status for seven CAN message queues behind an APB slave.
`timescale 1ns/1ps
`default_nettype none
module cmf_fifo_ctrl (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [6:0] engTxDone,
    input wire logic [6:0] engTxAbort,
    input wire logic [6:0] engTxFail,
    input wire logic [6:0] engLostArb,
    input wire logic [6:0] engBusErr,
    input wire logic [6:0] engRxStore,
    input wire logic [6:0] engRtrRx,
    output logic [6:0] sendPending,
    output logic [6:0] abortReq,
    output logic [6:0] timestampEn,
    output logic [48:0] payloadBytes,
    output logic [34:0] slotIndex,
    output logic [2:0] nextFifo,
    output logic nextValid,
    output logic fifoIrq
);
    localparam int N = cmf_pkg::NumFifo;

    wire access = psel & penable;
    wire setup = psel & ~penable;
    wire [2:0] selIdx = paddr[6:4];
    wire [1:0] selReg = paddr[3:2];
    wire modeHit = paddr == cmf_pkg::ModeRegAddr;
    wire fifoHit = ~paddr[7] && selIdx != 3'h7 && selReg != 2'h3
                   && paddr[1:0] == 2'h0;
    wire [15:0] wd = pwdata[15:0];
    wire wrMode = access & pwrite & modeHit & pstrb[0];

    logic [2:0] opMode;
    logic retryEn;
    logic [15:0] cfg [N];
    logic [7:0] ctl [N];
    logic [15:0] ctlRd [N];
    logic [15:0] staRd [N];
    logic [6:0] flushQ, sreq, abt, larb, err, exh, ovf;
    logic [6:0] pendC, irqVec;
    logic [4:0] head [N];
    logic [4:0] tail [N];
    logic [5:0] cnt [N];
    logic [1:0] tries [N];
    logic [2:0] bestIdx;
    logic [4:0] bestPri;
    logic bestV;
    logic [6:0] outranks;

    assign pready = 1'b1;
    assign pslverr = access & ~(modeHit | fifoHit);

    wire [15:0] rdVal = modeHit ? {12'h000, retryEn, opMode}
                      : !fifoHit ? 16'h0000
                      : selReg == cmf_pkg::CfgHighSel ? cfg[selIdx]
                      : selReg == cmf_pkg::CtrlLowSel ? ctlRd[selIdx]
                      : staRd[selIdx];

    // Read data is captured in the setup cycle so the slave needs no wait.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
        end else if (setup) begin
            prdata <= {16'h0000, rdVal};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            opMode <= cmf_pkg::ModeRst;
            retryEn <= 1'b0;
        end else if (wrMode) begin
            opMode <= wd[2:0];
            retryEn <= wd[cmf_pkg::RetryEnBit];
        end
    end

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_q
            wire hitQ = access & fifoHit & selIdx == 3'(i);
            wire wCfg = hitQ & pwrite & selReg == cmf_pkg::CfgHighSel;
            wire wCtl = hitQ & pwrite & selReg == cmf_pkg::CtrlLowSel;
            wire wSta = hitQ & pwrite & selReg == cmf_pkg::StatusSel
                        & pstrb[0];
            wire rSta = hitQ & ~pwrite & selReg == cmf_pkg::StatusSel;
            wire dir = ctl[i][cmf_pkg::DirBit];
            wire [4:0] last = cfg[i][cmf_pkg::DepthLo +: 5];
            wire [5:0] depth = {1'b0, last} + 6'h01;
            wire full = cnt[i] == depth;
            wire empty = cnt[i] == 6'h00;
            wire hiWr = wCtl & pstrb[1];
            wire swAdv = hiWr & wd[cmf_pkg::AdvBit];
            wire reqSet = hiWr & wd[cmf_pkg::ReqBit] & ~sreq[i] & dir;
            wire abortWr = hiWr & ~wd[cmf_pkg::ReqBit] & sreq[i] & dir;
            wire rtrSet = engRtrRx[i] & ctl[i][cmf_pkg::RtrBit];
            wire txDone = dir & engTxDone[i] & ~empty;
            wire rxStore = ~dir & engRxStore[i] & ~full;
            wire rxOver = ~dir & engRxStore[i] & full;
            // Transmit: software fills the head, the engine drains the tail.
            wire push = dir ? (swAdv & ~full) : rxStore;
            wire pop = dir ? txDone : (swAdv & ~empty);
            wire lastDone = txDone & cnt[i] == 6'h01 & ~push;
            wire [1:0] rsel = cfg[i][cmf_pkg::RetryLo +: 2];
            wire limited = retryEn & ~rsel[1];
            wire [1:0] maxTries = rsel[0] ? cmf_pkg::ThreeTries
                                          : cmf_pkg::NoRetryTries;
            wire fail = dir & sreq[i] & engTxFail[i];
            wire exhaust = fail & limited
                           & ({1'b0, tries[i]} + 3'h1 >= {1'b0, maxTries});
            wire evDone = dir & (engTxDone[i] | engTxAbort[i]);
            wire [4:0] slot = dir ? tail[i] : head[i];
            wire [6:0] lvl = {cnt[i], 1'b0};
            wire [2:0] fill = dir ? {empty, lvl <= {1'b0, depth}, ~full}
                                  : {full, lvl >= {1'b0, depth}, ~empty};
            wire [15:0] cfgNew = cmf_pkg::merge16(cfg[i], wd, pstrb[1:0]);
            wire cfgOpen = opMode == cmf_pkg::ConfigMode;

            assign ctlRd[i] = {5'h00, flushQ[i], sreq[i], 1'b0, ctl[i]};
            assign staRd[i] = {3'h0, slot, abt[i], larb[i], err[i],
                               exh[i] & dir, ovf[i] & ~dir, fill};
            assign pendC[i] = sreq[i] & dir & ~empty;
            assign outranks[i] = pendC[i]
                                 & (cfg[i][cmf_pkg::PrioLo +: 5] > bestPri);
            assign irqVec[i] = |({exh[i] & dir, ovf[i] & ~dir, fill}
                                 & ctl[i][4:0]);

            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    cfg[i] <= cmf_pkg::CfgHighRst;
                end else if (wCfg) begin
                    cfg[i] <= {cfgOpen ? cfgNew[15:8] : cfg[i][15:8],
                               cfgNew[7:0] & cmf_pkg::CfgLowMask};
                end
            end

            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    ctl[i] <= cmf_pkg::CtrlLowRst;
                end else if (wCtl & pstrb[0]) begin
                    ctl[i] <= wd[7:0];
                end
            end

            // Flush takes one cycle; the bit reads set until it is done.
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    flushQ[i] <= 1'b1;
                    head[i] <= 5'h00;
                    tail[i] <= 5'h00;
                    cnt[i] <= 6'h00;
                end else if (flushQ[i]) begin
                    flushQ[i] <= 1'b0;
                    head[i] <= 5'h00;
                    tail[i] <= 5'h00;
                    cnt[i] <= 6'h00;
                end else begin
                    flushQ[i] <= hiWr & wd[cmf_pkg::FlushBit];
                    if (push) begin
                        head[i] <= head[i] >= last ? 5'h00 : head[i] + 5'h01;
                    end
                    if (pop) begin
                        tail[i] <= tail[i] >= last ? 5'h00 : tail[i] + 5'h01;
                    end
                    cnt[i] <= cnt[i] + 6'(push) - 6'(pop);
                end
            end

            always_ff @(posedge clk) begin
                if (!rst_n || flushQ[i]) begin
                    sreq[i] <= 1'b0;
                    tries[i] <= 2'h0;
                end else begin
                    if (reqSet | rtrSet) begin
                        sreq[i] <= 1'b1;
                    end else if (abortWr | lastDone | exhaust) begin
                        sreq[i] <= 1'b0;
                    end
                    if (reqSet | txDone) begin
                        tries[i] <= 2'h0;
                    end else if (fail & ~exhaust) begin
                        tries[i] <= tries[i] + 2'h1;
                    end
                end
            end

            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    abortReq[i] <= 1'b0;
                end else begin
                    abortReq[i] <= abortWr | exhaust;
                end
            end

            // Hardware events win over a read or write clear in the same cycle; a flush wins over both.
            always_ff @(posedge clk) begin
                if (!rst_n || flushQ[i]) begin
                    abt[i] <= 1'b0;
                    larb[i] <= 1'b0;
                    err[i] <= 1'b0;
                    exh[i] <= 1'b0;
                    ovf[i] <= 1'b0;
                end else begin
                    if (evDone) begin
                        larb[i] <= engLostArb[i];
                        err[i] <= engBusErr[i];
                    end
                    if ((dir & engTxAbort[i]) | exhaust) begin
                        abt[i] <= 1'b1;
                    end else if (rSta | reqSet | txDone) begin
                        abt[i] <= 1'b0;
                    end
                    if (exhaust) begin
                        exh[i] <= 1'b1;
                    end else if (wSta & ~wd[cmf_pkg::ExhBit]) begin
                        exh[i] <= 1'b0;
                    end
                    if (rxOver) begin
                        ovf[i] <= 1'b1;
                    end else if (wSta & ~wd[cmf_pkg::OvfBit]) begin
                        ovf[i] <= 1'b0;
                    end
                end
            end

            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    payloadBytes[i*7 +: 7] <= 7'h08;
                    slotIndex[i*5 +: 5] <= 5'h00;
                    timestampEn[i] <= 1'b0;
                    sendPending[i] <= 1'b0;
                end else begin
                    payloadBytes[i*7 +: 7] <= cmf_pkg::decodePayload(
                        cfg[i][cmf_pkg::PayLo +: 3]);
                    slotIndex[i*5 +: 5] <= slot;
                    timestampEn[i] <= ctl[i][cmf_pkg::TsBit] & ~dir;
                    sendPending[i] <= pendC[i];
                end
            end

            a_flush_clears: assert property (@(posedge clk)
                disable iff (!rst_n) flushQ[i] |=> !flushQ[i]
                && cnt[i] == 6'h00 && !sreq[i] && !abt[i])
                else $error("flush did not reset queue");
            a_depth_bound: assert property (@(posedge clk)
                disable iff (!rst_n) cnt[i] <= depth && slot <= last)
                else $error("queue level beyond depth");
            a_cfg_locked: assert property (@(posedge clk)
                disable iff (!rst_n) wCfg && !cfgOpen
                |=> cfg[i][15:8] == $past(cfg[i][15:8]))
                else $error("size changed outside configuration");
            a_rx_no_send: assert property (@(posedge clk)
                disable iff (!rst_n) !dir && !rtrSet && !flushQ[i]
                |=> sreq[i] == $past(sreq[i]))
                else $error("receive queue changed send request");
            a_abort_pulse: assert property (@(posedge clk)
                disable iff (!rst_n) abortWr && !flushQ[i]
                |=> abortReq[i] && !sreq[i])
                else $error("abort not raised");
            a_exh_rx_zero: assert property (@(posedge clk)
                disable iff (!rst_n) !dir |-> !staRd[i][4] && staRd[i][3]
                == ovf[i])
                else $error("exhausted flag visible in receive");
            a_abt_read_clr: assert property (@(posedge clk)
                disable iff (!rst_n) rSta && !engTxAbort[i] && !exhaust
                |=> !abt[i])
                else $error("aborted flag survived read");
            a_drain_ends: assert property (@(posedge clk)
                disable iff (!rst_n) lastDone && !reqSet && !rtrSet
                && !flushQ[i] |=> !sreq[i] && cnt[i] == 6'h00)
                else $error("send request not cleared on drain");
            a_payload_max: assert property (@(posedge clk)
                disable iff (!rst_n) cfg[i][15:13] == 3'h7
                |=> payloadBytes[i*7 +: 7] == 7'h40)
                else $error("payload decode wrong");
        end
    endgenerate

    // Ties go to the lowest numbered queue.
    always_comb begin
        bestIdx = 3'h0;
        bestPri = 5'h00;
        bestV = 1'b0;
        for (int k = 0; k < N; k++) begin
            if (pendC[k] && (!bestV
                || cfg[k][cmf_pkg::PrioLo +: 5] > bestPri)) begin
                bestIdx = 3'(k);
                bestPri = cfg[k][cmf_pkg::PrioLo +: 5];
                bestV = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nextFifo <= 3'h0;
            nextValid <= 1'b0;
            fifoIrq <= 1'b0;
        end else begin
            nextFifo <= bestIdx;
            nextValid <= bestV;
            fifoIrq <= |irqVec;
        end
    end

    a_irq_follows: assert property (@(posedge clk) disable iff (!rst_n)
        fifoIrq == |$past(irqVec))
        else $error("interrupt does not follow enabled flags");
    a_prio_pick: assert property (@(posedge clk) disable iff (!rst_n)
        bestV |-> pendC[bestIdx] && outranks == 7'h00)
        else $error("picked queue not the highest pending");
endmodule
`default_nettype wire

//--- dv/cmf_engine_model.sv
// Behavioural CAN engine and message store facing the queue control.
`timescale 1ns/1ps
`default_nettype none
module cmf_engine_model #(
    parameter int Lat = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hold,
    input wire logic failNext,
    input wire logic arbLoss,
    input wire logic [6:0] rxReq,
    input wire logic [6:0] sendPending,
    input wire logic [6:0] abortReq,
    input wire logic [2:0] nextFifo,
    input wire logic nextValid,
    output logic [6:0] engTxDone,
    output logic [6:0] engTxAbort,
    output logic [6:0] engTxFail,
    output logic [6:0] engLostArb,
    output logic [6:0] engBusErr,
    output logic [6:0] engRxStore,
    output logic [6:0] engRtrRx
);
    logic [3:0] cnt;
    logic [2:0] cur;
    assign engLostArb = arbLoss ? 7'h7f : 7'h00;
    assign engBusErr = 7'h00;
    assign engRtrRx = 7'h00;
    // After each attempt the engine idles so the queue's new state settles.
    always_ff @(posedge clk) begin
        engTxDone <= 7'h00;
        engTxAbort <= 7'h00;
        engTxFail <= 7'h00;
        engRxStore <= rxReq;
        if (!rst_n) begin
            cnt <= 4'h0;
            cur <= 3'h0;
        end else if (|abortReq) begin
            engTxAbort <= abortReq;
            cnt <= 4'h0;
        end else if (cnt == 4'h0) begin
            if (nextValid && !hold) begin
                cur <= nextFifo;
                cnt <= 4'(Lat + 4);
            end
        end else begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h4) begin
                engTxFail[cur] <= failNext;
                engTxDone[cur] <= !failNext && sendPending[cur];
            end
        end
    end
endmodule
`default_nettype wire

//--- dv/cmf_fifo_ctrl_tb.sv
// Self-checking testbench for the message queue control.
`timescale 1ns/1ps
`default_nettype none
module cmf_fifo_ctrl_tb;
    logic clk = 1'b0;
    logic rst_n, psel, penable, pwrite, pready, pslverr, nextValid, fifoIrq;
    logic hold, failNext, arbLoss, errSeen;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [6:0] engTxDone, engTxAbort, engTxFail, engLostArb, engBusErr;
    logic [6:0] engRxStore, engRtrRx, sendPending, abortReq, timestampEn;
    logic [6:0] rxReq, firstVec;
    logic [48:0] payloadBytes;
    logic [34:0] slotIndex;
    logic [2:0] nextFifo;
    int mismatches, checksDone, doneCnt;
    localparam logic [6:0] Pay [8] = '{7'h08, 7'h0c, 7'h10, 7'h14,
                                      7'h18, 7'h20, 7'h30, 7'h40};

    always #10 clk = ~clk;

    cmf_fifo_ctrl i_cmf_fifo_ctrl (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .engTxDone(engTxDone), .engTxAbort(engTxAbort),
        .engTxFail(engTxFail), .engLostArb(engLostArb),
        .engBusErr(engBusErr), .engRxStore(engRxStore),
        .engRtrRx(engRtrRx), .sendPending(sendPending),
        .abortReq(abortReq), .timestampEn(timestampEn),
        .payloadBytes(payloadBytes), .slotIndex(slotIndex),
        .nextFifo(nextFifo), .nextValid(nextValid), .fifoIrq(fifoIrq));

    cmf_engine_model i_cmf_engine_model (.clk(clk), .rst_n(rst_n),
        .hold(hold), .failNext(failNext), .arbLoss(arbLoss), .rxReq(rxReq),
        .sendPending(sendPending), .abortReq(abortReq),
        .nextFifo(nextFifo), .nextValid(nextValid), .engTxDone(engTxDone),
        .engTxAbort(engTxAbort), .engTxFail(engTxFail),
        .engLostArb(engLostArb), .engBusErr(engBusErr),
        .engRxStore(engRxStore), .engRtrRx(engRtrRx));

    always @(posedge clk) begin
        if (|engTxDone) begin
            if (doneCnt == 0) firstVec = engTxDone;
            doneCnt++;
        end
    end

    task automatic chk(input string what, input logic [48:0] exp,
                       input logic [48:0] got);
        checksDone++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [15:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdreg(input logic [7:0] a);
        apb(1'b0, a, 16'h0000);
    endtask

    task automatic poll(input logic [7:0] a, input logic [15:0] m,
                        input logic [15:0] v);
        for (int i = 0; i < 40; i++) begin
            rdreg(a);
            if ((rd[15:0] & m) === v) break;
        end
        chk("polled register", v, rd[15:0] & m);
    endtask

    task automatic store(input logic [6:0] q);
        rxReq <= q;
        @(posedge clk);
        rxReq <= 7'h00;
        repeat (3) @(posedge clk);
    endtask

    task automatic t_reset;
        for (int q = 0; q < 7; q++) poll(8'(q * 16 + 4), 16'h0400, 16'h0);
        rdreg(8'h00);
        chk("config high", 32'h0060, rd);
        rdreg(8'h04);
        chk("control low", 32'h0, rd);
        chk("payload bytes", {7{7'h08}}, payloadBytes);
    endtask

    task automatic t_payload;
        for (int i = 0; i < 8; i++) begin
            wr(8'h10, {i[2:0], 13'h0060});
            @(posedge clk);
            chk("payload size", Pay[i], payloadBytes[13:7]);
        end
        wr(8'h70, 16'h0000);
        wr(8'h10, 16'h0060);
        chk("payload locked", 7'h40, payloadBytes[13:7]);
        rdreg(8'h10);
        chk("config locked", 32'he060, rd);
        wr(8'h70, 16'h0004);
    endtask

    task automatic t_transmit;
        hold <= 1'b1;
        wr(8'h20, 16'h0361);
        wr(8'h30, 16'h0065);
        wr(8'h24, 16'h0080);
        wr(8'h34, 16'h0080);
        for (int i = 0; i < 3; i++) wr(8'h24, 16'h0180);
        rdreg(8'h28);
        chk("three of four", 32'h0001, rd);
        wr(8'h24, 16'h0180);
        wr(8'h24, 16'h0180);
        rdreg(8'h28);
        chk("full at four", 32'h0000, rd);
        wr(8'h34, 16'h0180);
        doneCnt = 0;
        wr(8'h24, 16'h0280);
        wr(8'h34, 16'h0280);
        hold <= 1'b0;
        poll(8'h24, 16'h0200, 16'h0000);
        poll(8'h34, 16'h0200, 16'h0000);
        chk("first sent", 7'h08, firstVec);
        chk("messages sent", 5, doneCnt);
        rdreg(8'h28);
        chk("drained status", 32'h0007, rd);
        chk("slot index", 5'h00, slotIndex[14:10]);
    endtask

    task automatic t_abort;
        hold <= 1'b1;
        arbLoss <= 1'b1;
        wr(8'h44, 16'h0080);
        wr(8'h44, 16'h0180);
        wr(8'h44, 16'h0280);
        wr(8'h44, 16'h0080);
        repeat (4) @(posedge clk);
        poll(8'h48, 16'h00e0, 16'h00c0);
        rdreg(8'h48);
        chk("aborted after read", 16'h0040, rd[15:0] & 16'h00e0);
        wr(8'h44, 16'h0480);
        poll(8'h44, 16'h0400, 16'h0000);
        rdreg(8'h48);
        chk("after flush", 32'h0007, rd);
        arbLoss <= 1'b0;
        hold <= 1'b0;
    endtask

    task automatic t_receive;
        wr(8'h54, 16'h0228);
        rdreg(8'h54);
        chk("receive control", 32'h0028, rd);
        chk("timestamp", 1'b1, timestampEn[5]);
        store(7'h20);
        rdreg(8'h58);
        chk("receive full", 32'h0007, rd);
        chk("no pending", 1'b0, sendPending[5]);
        chk("irq quiet", 1'b0, fifoIrq);
        store(7'h20);
        rdreg(8'h58);
        chk("overflow", 32'h000f, rd);
        chk("irq overflow", 1'b1, fifoIrq);
        wr(8'h58, 16'h0000);
        rdreg(8'h58);
        chk("overflow cleared", 32'h0007, rd);
        chk("irq cleared", 1'b0, fifoIrq);
        wr(8'h54, 16'h0121);
        rdreg(8'h58);
        chk("tail advanced", 32'h0000, rd);
        chk("irq empty", 1'b0, fifoIrq);
        store(7'h20);
        chk("irq not empty", 1'b1, fifoIrq);
        wr(8'h54, 16'h0420);
        poll(8'h54, 16'h0400, 16'h0000);
    endtask

    task automatic t_retry;
        wr(8'h70, 16'h000c);
        wr(8'h60, 16'h0000);
        failNext <= 1'b1;
        wr(8'h64, 16'h0090);
        wr(8'h64, 16'h0190);
        wr(8'h64, 16'h0290);
        poll(8'h68, 16'h0090, 16'h0090);
        rdreg(8'h64);
        chk("request dropped", 32'h0090, rd);
        chk("irq exhausted", 1'b1, fifoIrq);
        wr(8'h68, 16'h0000);
        rdreg(8'h68);
        chk("exhausted cleared", 16'h0, rd[15:0] & 16'h0010);
        chk("irq released", 1'b0, fifoIrq);
        failNext <= 1'b0;
    endtask

    task automatic t_unmapped;
        rdreg(8'h0c);
        chk("unmapped error", 1'b1, errSeen);
        chk("unmapped data", 32'h0, rd);
        wr(8'h74, 16'hffff);
        chk("unmapped write", 1'b1, errSeen);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("Error watchdog expected end seen hang");
        close_out();
    end

    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite, hold, failNext, arbLoss} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h3;
        rxReq = 7'h00;
        firstVec = 7'h00;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_payload();
        t_transmit();
        t_abort();
        t_receive();
        t_retry();
        t_unmapped();
        close_out();
    end
endmodule
`default_nettype wire
